// file: core/vpd_pkg.sv
/*
 * Shared constants and types of the serial-EEPROM product-data engine.
 * Assumes both clock domains of the engine see the same definitions.
 */
// Operation
// R1 - Engine works only when feature enable is set and an EEPROM exists.
// R2 - After reset, accesses go to EEPROM select zero; software may change it.
// R3 - With select zero, add 64 to each address before sending to EEPROM.
// R4 - Select zero: first 64 visible bytes read-only, next 128 read/write.
// R5 - Nonzero select: first 64 bytes read-only, upper 192 read/write.
// R6 - Byte pointer is 8 bits, covering at most 256 bytes.
// R7 - Select zero reads reach 0x00-0xbf only; others reach all 256.
// R8 - Software gives aligned pointers; each access moves four bytes.
// R9 - Software starts a read by writing pointer with flag cleared.
// R10 - After fetching four bytes into payload, engine sets the flag.
// R11 - Payload bits 7:0 hold the pointed byte, bytes 1-3 the next ones.
// R12 - Software leaves payload and direct control alone until read ends.
// R13 - Software loads payload, then writes pointer with flag set.
// R14 - When the four-byte write is finished, engine clears the flag.
// R15 - Writes only reach the read/write part of the selected EEPROM.
// R16 - A write into the lowest 64 bytes is skipped and flag cleared.
// R17 - Software leaves payload and direct control alone during writes.
// R18 - Software takes the shared lock before using the serial bus.
// R19 - Capability and payload registers sit in primary config space.
// R20 - Bytes go out one by one; flag changes after last byte acked.
package vpd_pkg;

	localparam logic [2:0] VPD_SELECT_RESET = 3'h0;
	localparam logic [7:0] VPD_HIDE_OFFSET = 8'h40;
	localparam logic [7:0] VPD_READ_ONLY_LIMIT = 8'h40;
	localparam logic [7:0] VPD_SEL0_TOP = 8'hbf;
	localparam logic [31:0] VPD_BLANK_DATA = 32'hffffffff;
	localparam logic [3:0] VPD_DEVICE_TYPE = 4'ha;
	localparam int VPD_QUARTER_CYCLES = 52;
	localparam logic [2:0] VPD_WRITE_LAST = 3'h5;
	localparam logic [2:0] VPD_READ_LAST = 3'h6;
	localparam logic [2:0] VPD_READ_FIRST = 3'h3;
	localparam logic [3:0] VPD_ACK_BIT = 4'h8;

	typedef struct packed {
		logic write;
		logic [2:0] select;
		logic [7:0] eaddr;
		logic [31:0] wdata;
	} vpd_req_t;

endpackage

// file: core/vpd_sync.sv
/*
 * Three-stage synchroniser for a level from another clock domain.
 * Assumes the input changes no faster than a few destination clocks.
 */
module vpd_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_level
);

	logic s1;
	logic s2;
	logic s3;

	// The level only moves once the last two stages agree.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			o_level <= RESET_VAL;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				o_level <= s3;
			end
		end
	end

endmodule

// file: core/vpd_rst_sync.sv
/*
 * Reset bridge: asserts at once, releases on the destination clock.
 * Assumes the source reset is asynchronous and active high.
 */
module vpd_rst_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	output logic o_rst
);

	logic hold;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hold <= 1'b1;
			o_rst <= 1'b1;
		end else begin
			hold <= 1'b0;
			o_rst <= hold;
		end
	end

endmodule

// file: core/vpd_eeprom_access.sv
/*
 * Product-data access engine: capability flag handshake on the primary
 * configuration clock, and a two-wire master on the link clock that moves
 * four EEPROM bytes per request.
 * Assumes open-drain pads outside, the shared lock already taken by
 * software, and configuration writes decoded by the config space logic.
 */
module vpd_eeprom_access #(
	parameter int QUARTER_CYCLES = vpd_pkg::VPD_QUARTER_CYCLES
) (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_LINK_CLK,
	input wire logic i_vpd_feature_enable,
	input wire logic i_eeprom_present,
	input wire logic i_select_wr,
	input wire logic [2:0] i_select_wdata,
	input wire logic i_cap_wr,
	input wire logic [7:0] i_cap_pointer,
	input wire logic i_cap_flag,
	input wire logic i_payload_wr,
	input wire logic [31:0] i_payload_wdata,
	input wire logic I_SCL_IN,
	input wire logic I_SDA_IN,
	output logic O_SCL_OUT,
	output logic O_SCL_OE,
	output logic O_SDA_OUT,
	output logic O_SDA_OE,
	output logic o_available,
	output logic [2:0] o_vpd_eeprom_select,
	output logic [7:0] o_vpd_byte_pointer,
	output logic o_flag,
	output logic [31:0] o_vpd_payload_register,
	output logic o_busy
);

	typedef enum logic {C_IDLE, C_WAIT} vpd_core_state_t;
	typedef enum logic [1:0] {L_IDLE, L_START, L_BITS, L_STOP} vpd_link_state_t;

	// Core domain.
	vpd_core_state_t cstate;
	vpd_pkg::vpd_req_t req;
	logic req_tgl;
	logic done_seen;
	logic done_sync;
	logic launch;
	logic protect;
	logic out_range;
	logic take;

	// Link domain.
	logic lrst;
	vpd_link_state_t lstate;
	vpd_pkg::vpd_req_t lreq;
	logic req_sync;
	logic req_seen;
	logic done_tgl;
	logic [31:0] rdata;
	logic [1:0] quarter;
	logic [15:0] cnt;
	logic tick;
	logic [3:0] bitn;
	logic [2:0] bidx;
	logic [7:0] shifter;
	logic sbit;
	logic retry;
	logic scl_s;
	logic sda_s;
	logic is_rx;
	logic [2:0] last_idx;
	logic txbit;
	logic next_scl_oe;
	logic next_sda_oe;

	function automatic logic [7:0] tx_byte(input logic [2:0] idx,
			input vpd_pkg::vpd_req_t r);
		logic [7:0] b;
		b = 8'h00;
		if (idx == 3'h0) begin
			b = {vpd_pkg::VPD_DEVICE_TYPE, r.select, 1'b0};
		end else if (idx == 3'h1) begin
			b = r.eaddr;
		end else if (!r.write) begin
			b = {vpd_pkg::VPD_DEVICE_TYPE, r.select, 1'b1};
		end else begin
			b = r.wdata[8 * (idx - 3'h2) +: 8];
		end
		return b;
	endfunction

	assign o_available = i_vpd_feature_enable & i_eeprom_present; // R1
	assign o_busy = (cstate == C_WAIT);
	assign O_SCL_OUT = 1'b0;
	assign O_SDA_OUT = 1'b0;

	// Requests arrive as config writes to the capability of the primary
	// interface; a write while busy or while disabled is dropped.
	assign take = i_cap_wr && o_available && cstate == C_IDLE; // R1 R19
	// Only writes are refused in the protected low 64 pointer values; reads pass.
	assign protect = i_cap_pointer < vpd_pkg::VPD_READ_ONLY_LIMIT; // R4 R5
	assign out_range = o_vpd_eeprom_select == 3'h0 &&
		i_cap_pointer > vpd_pkg::VPD_SEL0_TOP; // R7
	assign launch = take && !out_range && !(i_cap_flag && protect); // R15

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			o_vpd_eeprom_select <= vpd_pkg::VPD_SELECT_RESET; // R2
		end else if (i_select_wr) begin
			o_vpd_eeprom_select <= i_select_wdata; // R2
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			cstate <= C_IDLE;
			o_vpd_byte_pointer <= 8'h00;
			o_flag <= 1'b0;
		end else if (cstate == C_IDLE) begin
			if (take) begin
				o_vpd_byte_pointer <= i_cap_pointer; // R6
				if (launch) begin
					cstate <= C_WAIT;
					o_flag <= i_cap_flag; // R9 R13
				end else if (i_cap_flag) begin
					o_flag <= 1'b0; // R16
				end else begin
					o_flag <= 1'b1;
				end
			end
		end else if (done_sync != done_seen) begin
			cstate <= C_IDLE;
			o_flag <= !req.write; // R10 R14 R20
		end
	end

	// Payload is held against software while a transfer runs; the link domain
	// reads the write data from the request word copied at launch.
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			o_vpd_payload_register <= 32'h00000000;
		end else if (cstate == C_WAIT) begin
			if (done_sync != done_seen && !req.write) begin
				o_vpd_payload_register <= rdata; // R10 R11
			end
		end else if (take && out_range && !i_cap_flag) begin
			o_vpd_payload_register <= vpd_pkg::VPD_BLANK_DATA; // R7
		end else if (i_payload_wr) begin
			o_vpd_payload_register <= i_payload_wdata; // R13
		end
	end

	// The request word is frozen from launch to done, so the link domain
	// may sample it any time after it sees the toggle.
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			req <= '0;
			req_tgl <= 1'b0;
			done_seen <= 1'b0;
		end else begin
			if (launch) begin
				req.write <= i_cap_flag;
				req.select <= o_vpd_eeprom_select;
				if (o_vpd_eeprom_select == 3'h0) begin
					req.eaddr <= i_cap_pointer +
						vpd_pkg::VPD_HIDE_OFFSET; // R3
				end else begin
					req.eaddr <= i_cap_pointer; // R8
				end
				req.wdata <= o_vpd_payload_register; // R11
				req_tgl <= !req_tgl;
			end
			if (cstate == C_WAIT && done_sync != done_seen) begin
				done_seen <= done_sync;
			end
		end
	end

	vpd_sync u_done_sync (
		.i_clk(I_MCLK),
		.i_rst(I_RST),
		.i_async(done_tgl),
		.o_level(done_sync)
	);

	vpd_rst_sync u_link_rst (
		.i_clk(I_LINK_CLK),
		.i_rst(I_RST),
		.o_rst(lrst)
	);

	vpd_sync u_req_sync (
		.i_clk(I_LINK_CLK),
		.i_rst(lrst),
		.i_async(req_tgl),
		.o_level(req_sync)
	);

	vpd_sync #(.RESET_VAL(1'b1)) u_scl_sync (
		.i_clk(I_LINK_CLK),
		.i_rst(lrst),
		.i_async(I_SCL_IN),
		.o_level(scl_s)
	);

	vpd_sync #(.RESET_VAL(1'b1)) u_sda_sync (
		.i_clk(I_LINK_CLK),
		.i_rst(lrst),
		.i_async(I_SDA_IN),
		.o_level(sda_s)
	);

	assign is_rx = !lreq.write && bidx >= vpd_pkg::VPD_READ_FIRST;
	assign last_idx = lreq.write ? vpd_pkg::VPD_WRITE_LAST :
		vpd_pkg::VPD_READ_LAST;
	// Clock stretching by the EEPROM holds the first high quarter (quarter 1) open.
	assign tick = cnt == 16'(QUARTER_CYCLES - 1) &&
		!(quarter == 2'h1 && !scl_s);

	always_comb begin
		if (bitn != vpd_pkg::VPD_ACK_BIT) begin
			txbit = is_rx ? 1'b1 : shifter[7];
		end else begin
			txbit = !is_rx || bidx == last_idx;
		end
	end

	// Pin levels for each quarter of a symbol; enable high pulls low.
	always_comb begin
		next_scl_oe = 1'b0;
		next_sda_oe = 1'b0;
		unique case (lstate)
			L_IDLE: begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
			end
			L_START: begin
				next_scl_oe = quarter == 2'h0 || quarter == 2'h3;
				next_sda_oe = quarter >= 2'h2;
			end
			L_BITS: begin
				next_scl_oe = quarter == 2'h0 || quarter == 2'h3;
				next_sda_oe = !txbit;
			end
			L_STOP: begin
				next_scl_oe = quarter == 2'h0;
				next_sda_oe = quarter <= 2'h1;
			end
		endcase
	end

	always_ff @(posedge I_LINK_CLK or posedge lrst) begin
		if (lrst) begin
			O_SCL_OE <= 1'b0;
			O_SDA_OE <= 1'b0;
		end else begin
			O_SCL_OE <= next_scl_oe;
			O_SDA_OE <= next_sda_oe;
		end
	end

	always_ff @(posedge I_LINK_CLK or posedge lrst) begin
		if (lrst) begin
			cnt <= 16'h0000;
			quarter <= 2'h0;
			sbit <= 1'b1;
		end else if (lstate == L_IDLE) begin
			cnt <= 16'h0000;
			quarter <= 2'h0;
		end else if (tick) begin
			cnt <= 16'h0000;
			quarter <= quarter + 2'h1;
			if (quarter == 2'h2) begin
				sbit <= sda_s;
			end
		end else if (!(quarter == 2'h1 && !scl_s)) begin
			cnt <= cnt + 16'h0001;
		end
	end

	// One byte at a time, nine clocks each; a refused acknowledge (EEPROM
	// still in its internal write cycle) stops and retries the whole
	// transfer, so the flag never moves before the last byte is taken.
	always_ff @(posedge I_LINK_CLK or posedge lrst) begin
		if (lrst) begin
			lstate <= L_IDLE;
			lreq <= '0;
			req_seen <= 1'b0;
			done_tgl <= 1'b0;
			rdata <= 32'h00000000;
			bitn <= 4'h0;
			bidx <= 3'h0;
			shifter <= 8'h00;
			retry <= 1'b0;
		end else begin
			unique case (lstate)
				L_IDLE: begin
					if (req_sync != req_seen) begin
						req_seen <= req_sync;
						lreq <= req;
						bidx <= 3'h0;
						lstate <= L_START;
					end
				end
				L_START: begin
					if (tick && quarter == 2'h3) begin
						bitn <= 4'h0;
						shifter <= tx_byte(bidx, lreq);
						lstate <= L_BITS;
					end
				end
				L_BITS: begin
					if (tick && quarter == 2'h3) begin
						if (bitn != vpd_pkg::VPD_ACK_BIT) begin
							shifter <= {shifter[6:0], sbit};
							bitn <= bitn + 4'h1;
						end else if (!is_rx && sbit) begin
							retry <= 1'b1;
							lstate <= L_STOP;
						end else begin
							if (is_rx) begin
								rdata[8 * (bidx - 3'h3) +: 8] <=
									shifter; // R11
							end
							if (bidx == last_idx) begin
								retry <= 1'b0;
								lstate <= L_STOP; // R20
							end else if (!lreq.write && bidx == 3'h1) begin
								bidx <= 3'h2;
								lstate <= L_START;
							end else begin
								bidx <= bidx + 3'h1;
								bitn <= 4'h0;
								shifter <= tx_byte(bidx + 3'h1, lreq); // R20
							end
						end
					end
				end
				L_STOP: begin
					if (tick && quarter == 2'h3) begin
						if (retry) begin
							bidx <= 3'h0;
							lstate <= L_START;
						end else begin
							done_tgl <= !done_tgl; // R10 R14
							lstate <= L_IDLE;
						end
					end
				end
			endcase
		end
	end

endmodule

// file: sim/vpd_monitor.sv
/* Checker of the engine's capability-flag handshake.
   Assumes it is bound to the engine and sees its ports only. */
module vpd_monitor (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic i_vpd_feature_enable,
	input wire logic i_eeprom_present,
	input wire logic i_cap_wr,
	input wire logic [7:0] i_cap_pointer,
	input wire logic i_cap_flag,
	input wire logic o_available,
	input wire logic [2:0] o_vpd_eeprom_select,
	input wire logic [7:0] o_vpd_byte_pointer,
	input wire logic o_flag,
	input wire logic [31:0] o_vpd_payload_register,
	input wire logic o_busy
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	logic take;
	logic low;
	logic kind;
	assign take = i_cap_wr && o_available && !o_busy;
	assign low = o_vpd_eeprom_select == 3'h0;
	// The kind is kept because completion drives the flag opposite ways.
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			kind <= 1'b0;
		else if (take)
			kind <= i_cap_flag;
	end
	sequence rd_go;
		take && !i_cap_flag && !(low && i_cap_pointer > 8'hbf);
	endsequence
	sequence wr_go;
		take && i_cap_flag && i_cap_pointer > 8'h3f
			&& !(low && i_cap_pointer > 8'hbf);
	endsequence
	chk_avail_level: assert property (
		o_available == (i_vpd_feature_enable && i_eeprom_present))
		else $error("available level wrong");
	chk_off_ignored: assert property (
		i_cap_wr && !o_available && !o_busy |=> !o_busy && $stable(o_flag))
		else $error("request taken while unavailable");
	chk_read_range: assert property (
		take && !i_cap_flag && low && i_cap_pointer > 8'hbf |=> o_flag
		&& !o_busy && o_vpd_payload_register == 32'hffffffff)
		else $error("out of range read wrong");
	chk_write_guard: assert property (
		take && i_cap_flag && (i_cap_pointer < 8'h40
		|| low && i_cap_pointer > 8'hbf) |=> !o_flag && !o_busy)
		else $error("protected write not skipped");
	chk_read_start: assert property (
		rd_go |=> o_busy && !o_flag
		&& o_vpd_byte_pointer == $past(i_cap_pointer))
		else $error("read not started");
	chk_write_start: assert property (
		wr_go |=> o_busy && o_flag)
		else $error("write not started");
	chk_flag_done: assert property (
		$fell(o_busy) |-> o_flag == !kind)
		else $error("completion flag wrong");
	chk_flag_hold: assert property (
		o_busy ##1 o_busy |-> $stable(o_flag) && $stable(o_vpd_byte_pointer))
		else $error("flag moved during transfer");
endmodule

bind vpd_eeprom_access vpd_monitor u_mon (.I_MCLK, .I_RST,
	.i_vpd_feature_enable, .i_eeprom_present, .i_cap_wr, .i_cap_pointer,
	.i_cap_flag, .o_available, .o_vpd_eeprom_select, .o_vpd_byte_pointer,
	.o_flag, .o_vpd_payload_register, .o_busy);

// file: sim/vpd_rom_model.sv
/* Serial EEPROM on the two-wire bus, one 256-byte bank per chip select.
   Assumes pulled-up wires, so releasing a line lets it go high. */
module vpd_rom_model (
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_slow,
	output logic o_scl_pull,
	output logic o_sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [2048];
	logic [7:0] sh;
	logic [7:0] ptr;
	logic [2:0] sel;
	logic rd;
	logic act;
	int cnt;
	int byten;
	int wip;
	initial begin
		o_scl_pull = 1'b0;
		o_sda_pull = 1'b0;
		act = 1'b0;
		wip = 0;
		for (int i = 0; i < 2048; i++)
			mem[i] = 8'(i) ^ {3'(i >> 8), 5'h00};
	end
	always @(negedge i_sda) begin
		if (i_scl) begin
			act = 1'b1;
			rd = 1'b0;
			cnt = -1;
			byten = 0;
		end
	end
	// After a write the part is busy inside and refuses its address twice,
	// so the engine has to poll for the acknowledge.
	always @(posedge i_sda) begin
		if (i_scl) begin
			if (act && !rd && byten > 2)
				wip = 2;
			act = 1'b0;
		end
	end
	// A released acknowledge after a read byte ends the read, so the wire
	// is let go in time for the stop that follows.
	always @(posedge i_scl) begin
		if (act && !rd && cnt < 8)
			sh = {sh[6:0], i_sda};
		else if (act && rd && cnt == 8 && i_sda)
			act = 1'b0;
	end
	// Data moves only while the clock is low, so it never fakes a start.
	always @(negedge i_scl) begin
		if (act) begin
			cnt = (cnt == 8) ? 0 : cnt + 1;
			if (cnt == 8 && rd) begin
				o_sda_pull = 1'b0;
				ptr++;
			end else if (cnt == 8 && byten == 0 && wip > 0) begin
				wip--;
				act = 1'b0;
			end else if (cnt == 8) begin
				if (byten == 0)
					{sel, rd} = sh[3:0];
				else if (byten == 1)
					ptr = sh;
				else
					mem[{sel, ptr++}] = sh;
				byten++;
				o_sda_pull = 1'b1;
			end else
				o_sda_pull = rd && !mem[{sel, ptr}][7 - cnt];
			if (i_slow) begin
				o_scl_pull = 1'b1;
				#300;
				o_scl_pull = 1'b0;
			end
		end
	end
endmodule

// file: sim/tb_top.sv
/* Self-checking bench of the product-data engine with an EEPROM model.
   Assumes pulled-up two-wire lines, resolved here from both pull enables. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_MCLK = 1'b0;
	logic I_RST = 1'b1;
	logic I_LINK_CLK = 1'b0;
	logic present = 1'b1;
	logic sel_wr = 1'b0;
	logic [2:0] sel_d = 3'h0;
	logic cap_wr = 1'b0;
	logic [7:0] ptr = 8'h00;
	logic flag = 1'b0;
	logic pay_wr = 1'b0;
	logic [31:0] pay_d = 32'h0;
	logic slow = 1'b0;
	logic scl_oe, sda_oe, m_scl, m_sda, avail, f_o, busy;
	logic scl_lvl, sda_lvl;
	logic [2:0] sel_o;
	logic [31:0] pay_o;
	logic [31:0] dat;
	int errors = 0;
	int total_checks = 0;
	initial forever #4 I_MCLK = !I_MCLK;
	initial begin
		#1.3;
		forever #6 I_LINK_CLK = !I_LINK_CLK;
	end
	vpd_eeprom_access #(.QUARTER_CYCLES(6)) dut (
		.I_MCLK(I_MCLK), .I_RST(I_RST), .I_LINK_CLK(I_LINK_CLK),
		.i_vpd_feature_enable(1'b1), .i_eeprom_present(present),
		.i_select_wr(sel_wr), .i_select_wdata(sel_d), .i_cap_wr(cap_wr),
		.i_cap_pointer(ptr), .i_cap_flag(flag), .i_payload_wr(pay_wr),
		.i_payload_wdata(pay_d), .I_SCL_IN(!(scl_oe || m_scl)),
		.I_SDA_IN(!(sda_oe || m_sda)), .O_SCL_OUT(scl_lvl),
		.O_SCL_OE(scl_oe), .O_SDA_OUT(sda_lvl), .O_SDA_OE(sda_oe),
		.o_available(avail),
		.o_vpd_eeprom_select(sel_o), .o_vpd_byte_pointer(), .o_flag(f_o),
		.o_vpd_payload_register(pay_o), .o_busy(busy));
	vpd_rom_model eeprom (.i_scl(!(scl_oe || m_scl)),
		.i_sda(!(sda_oe || m_sda)), .i_slow(slow), .o_scl_pull(m_scl),
		.o_sda_pull(m_sda));
	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] pat(input int s, input logic [7:0] a);
		for (int k = 0; k < 4; k++)
			pat[8 * k +: 8] = (a + 8'(k)) ^ {3'(s), 5'h00};
	endfunction
	task automatic poke(input logic k, input logic [31:0] d);
		@(posedge I_MCLK);
		sel_wr <= !k;
		pay_wr <= k;
		sel_d <= d[2:0];
		pay_d <= d;
		@(posedge I_MCLK);
		sel_wr <= 1'b0;
		pay_wr <= 1'b0;
	endtask
	// Software polls until idle, so payload is never touched mid-transfer.
	task automatic go(input logic [7:0] p, input logic f);
		int n;
		@(posedge I_MCLK);
		cap_wr <= 1'b1;
		ptr <= p;
		flag <= f;
		@(posedge I_MCLK);
		cap_wr <= 1'b0;
		@(negedge I_MCLK);
		for (n = 0; busy !== 1'b0 && n < 20000; n++)
			@(negedge I_MCLK);
		chk("idle", 32'(busy), 32'h0);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#600000;
		errors++;
		wrap_up;
	end
	// Nothing else drives the wires, which stands for the shared lock held.
	initial begin
		repeat (2) @(posedge I_MCLK);
		I_RST <= 1'b0;
		@(negedge I_MCLK);
		chk("select", 32'(sel_o), 32'h0);
		chk("pad level", 32'({scl_lvl, sda_lvl}), 32'h0);
		@(posedge I_MCLK) present <= 1'b0;
		go(8'h00, 1'b0);
		chk("absent", 32'({avail, busy, f_o}), 32'h0);
		@(posedge I_MCLK) present <= 1'b1;
		go(8'h00, 1'b0);
		chk("rd sel0", pay_o, pat(0, 8'h40));
		chk("rd flag", 32'(f_o), 32'h1);
		go(8'hc0, 1'b0);
		chk("rd high", pay_o, 32'hffffffff);
		go(8'hc0, 1'b1);
		chk("wr high", 32'({f_o, busy}), 32'h0);
		// Aligned pointers only; bank 3 runs with clock stretching.
		for (int s = 0; s < 4; s += 3) begin
			poke(1'b0, 32'(s));
			slow = s != 0;
			dat = 32'hc3a51e00 | 32'(s);
			poke(1'b1, dat);
			go(8'h3c, 1'b1);
			chk("ro flag", 32'({f_o, busy}), 32'h0);
			go(8'h3c, 1'b0);
			chk("ro keep", pay_o, pat(s, s != 0 ? 8'h3c : 8'h7c));
			poke(1'b1, dat);
			go(s != 0 ? 8'h40 : 8'h80, 1'b1);
			chk("wr flag", 32'(f_o), 32'h0);
			chk("wr land", 32'(eeprom.mem[s != 0 ? 832 : 192]),
				32'(dat[7:0]));
			go(s != 0 ? 8'h40 : 8'h80, 1'b0);
			chk("wr back", pay_o, dat);
		end
		chk("select", 32'(sel_o), 32'h3);
		go(8'hfc, 1'b0);
		chk("rd top", pay_o, pat(3, 8'hfc));
		wrap_up;
	end
endmodule
